// ==== verilog/lpc_pkg.sv ====
// Constants, register map and helper functions for the pixel clock pattern and mask block
package lpc_pkg;

   // ------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int IDX_W = 4;
   localparam int IDX_LSB = 2;
   localparam int NREG = 15;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Register indices (byte address is index times four)
   // ------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_CTRL = 4'h0;
   localparam logic [IDX_W-1:0] IDX_PRI_WORD0 = 4'h1;
   localparam logic [IDX_W-1:0] IDX_AUX_WORD0 = 4'h5;
   localparam logic [IDX_W-1:0] IDX_AUX_WORD2 = 4'h7;
   localparam logic [IDX_W-1:0] IDX_AUX_WORD3 = 4'h8;
   localparam logic [IDX_W-1:0] IDX_HSTART = 4'h9;
   localparam logic [IDX_W-1:0] IDX_HSTART_AUX = 4'hA;
   localparam logic [IDX_W-1:0] IDX_HRANGE = 4'hB;
   localparam logic [IDX_W-1:0] IDX_VSTART = 4'hC;
   localparam logic [IDX_W-1:0] IDX_VRANGE = 4'hD;
   localparam logic [IDX_W-1:0] IDX_STATUS = 4'hE;
   localparam int PAT_WORDS = 4;

   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int CNT_W = 13;
   localparam int PAT_W = 16;
   localparam int PAT_BITS = 64;
   localparam int WIDTH_W = 6;
   localparam int CTRL_WIDTH_LSB = 0;
   localparam int CTRL_MASK_EN_BIT = 10;
   localparam int CTRL_GATING_BIT = 11;
   localparam int CTRL_INT_MODE_BIT = 15;
   localparam int CTRL_SWITCH_BIT = 16;
   localparam int STAT_HCNT_LSB = 0;
   localparam int STAT_LCNT_LSB = 16;
   localparam int STAT_AUX_BIT = 30;
   localparam int STAT_WIN_BIT = 31;
   localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h00018C3F;
   localparam logic [DATA_W-1:0] PAT_WMASK = 32'h0000FFFF;
   localparam logic [DATA_W-1:0] POS_WMASK = 32'h00001FFF;
   localparam logic [DATA_W-1:0] REG_RESET = 32'h00000000;
   localparam logic [CNT_W-1:0] CNT_MAX = 13'h1FFF;

   // ------------------------------------------------------------
   // Decoding shared by the bus slave and the register file
   // ------------------------------------------------------------
   function automatic logic [IDX_W-1:0] lpc_idx(input logic [ADDR_W-1:0] addr);
      lpc_idx = addr[IDX_LSB +: IDX_W];
   endfunction

   function automatic logic lpc_hit(input logic [ADDR_W-1:0] addr);
      lpc_hit = (addr[ADDR_W-1:IDX_LSB+IDX_W] == '0) && (lpc_idx(addr) <= IDX_STATUS);
   endfunction

   function automatic logic [DATA_W-1:0] lpc_wmask(input logic [IDX_W-1:0] idx);
      if (idx == IDX_CTRL) begin
         lpc_wmask = CTRL_WMASK;
      end else if (idx < IDX_HSTART) begin
         lpc_wmask = PAT_WMASK;
      end else if (idx < IDX_STATUS) begin
         lpc_wmask = POS_WMASK;
      end else begin
         lpc_wmask = '0;
      end
   endfunction

   function automatic logic lpc_in_window(input logic [CNT_W-1:0] cnt,
                                          input logic [CNT_W-1:0] start,
                                          input logic [CNT_W-1:0] range);
      lpc_in_window = ({1'b0, cnt} >= {1'b0, start}) &&
                      ({1'b0, cnt} < ({1'b0, start} + {1'b0, range}));
   endfunction

endpackage

// ==== verilog/lpc_regbus_if.sv ====
// Register access path between the bus slave and the register file
`timescale 1ns/1ps
`default_nettype none
interface lpc_regbus_if;
   import lpc_pkg::*;
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [STRB_W-1:0] wr_strb;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   modport slave (output wr_en, output wr_addr, output wr_data, output wr_strb,
                  output rd_addr, input rd_data);
   modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb,
                 input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ==== verilog/lpc_pattern_stepper.sv ====
// Pattern bit index that walks the valid bits and re-aligns on each line
`timescale 1ns/1ps
`default_nettype none
module lpc_pattern_stepper
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic restart,
   input wire logic [lpc_pkg::WIDTH_W-1:0] last_idx,
   output var logic [lpc_pkg::WIDTH_W-1:0] idx_ff
);
   import lpc_pkg::*;
   logic [WIDTH_W-1:0] nxt_idx;

   always_comb begin
      if (restart) begin
         nxt_idx = '0;
      end else if (idx_ff >= last_idx) begin
         nxt_idx = '0;
      end else begin
         nxt_idx = idx_ff + 6'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         idx_ff <= '0;
      end else begin
         idx_ff <= nxt_idx;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/lpc_axi_slave.sv ====
// AXI4-Lite slave front end for the register file
`timescale 1ns/1ps
`default_nettype none
module lpc_axi_slave
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [lpc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output var logic s_axi_awready,
   input wire logic [lpc_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [lpc_pkg::STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output var logic s_axi_wready,
   output var logic [1:0] s_axi_bresp,
   output var logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [lpc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output var logic s_axi_arready,
   output var logic [lpc_pkg::DATA_W-1:0] s_axi_rdata,
   output var logic [1:0] s_axi_rresp,
   output var logic s_axi_rvalid,
   input wire logic s_axi_rready,
   lpc_regbus_if.slave bus
);
   import lpc_pkg::*;
   logic aw_got_ff, w_got_ff, nxt_aw_got, nxt_w_got;
   logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
   logic [DATA_W-1:0] w_data_ff, nxt_w_data, nxt_rdata;
   logic [STRB_W-1:0] w_strb_ff, nxt_w_strb;
   logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
   logic [1:0] nxt_bresp, nxt_rresp;
   logic do_wr, ar_fire;

   // ------------------------------------------------------------
   // Write and read channels
   // ------------------------------------------------------------
   assign do_wr = aw_got_ff && w_got_ff && !s_axi_bvalid;
   assign ar_fire = s_axi_arvalid && s_axi_arready;
   assign bus.wr_en = do_wr && lpc_hit(aw_addr_ff);
   assign bus.wr_addr = aw_addr_ff;
   assign bus.wr_data = w_data_ff;
   assign bus.wr_strb = w_strb_ff;
   assign bus.rd_addr = s_axi_araddr;

   always_comb begin
      nxt_aw_got = aw_got_ff || (s_axi_awvalid && s_axi_awready);
      nxt_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr_ff;
      nxt_w_got = w_got_ff || (s_axi_wvalid && s_axi_wready);
      nxt_w_data = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data_ff;
      nxt_w_strb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb_ff;
      nxt_bvalid = s_axi_bvalid && !s_axi_bready;
      nxt_bresp = s_axi_bresp;
      if (do_wr) begin
         nxt_aw_got = 1'b0;
         nxt_w_got = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = lpc_hit(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
      nxt_awready = !nxt_aw_got && !nxt_bvalid;
      nxt_wready = !nxt_w_got && !nxt_bvalid;
      nxt_rvalid = ar_fire || (s_axi_rvalid && !s_axi_rready);
      nxt_rdata = ar_fire ? (lpc_hit(s_axi_araddr) ? bus.rd_data : '0) : s_axi_rdata;
      nxt_rresp = ar_fire ? (lpc_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR) : s_axi_rresp;
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         aw_addr_ff <= '0;
         w_data_ff <= '0;
         w_strb_ff <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         aw_got_ff <= nxt_aw_got;
         w_got_ff <= nxt_w_got;
         aw_addr_ff <= nxt_aw_addr;
         w_data_ff <= nxt_w_data;
         w_strb_ff <= nxt_w_strb;
         s_axi_awready <= nxt_awready;
         s_axi_wready <= nxt_wready;
         s_axi_bvalid <= nxt_bvalid;
         s_axi_bresp <= nxt_bresp;
         s_axi_arready <= nxt_arready;
         s_axi_rvalid <= nxt_rvalid;
         s_axi_rdata <= nxt_rdata;
         s_axi_rresp <= nxt_rresp;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/lpc_pixel_clock_mask.sv ====
// Pixel clock pattern generator with auxiliary pattern and mask window
//
// Summary of operation
// - Auxiliary pattern bits 47..32 sit in bits 15..0 of auxiliary word 2.
// - Auxiliary pattern bits 63..48 sit in bits 15..0 of auxiliary word 3.
// - One pattern bit leaves per core clock cycle.
// - With line switching on and internal mode off, culling line ID 1 uses the auxiliary pattern.
// - With line switching off, auxiliary registers do not affect the output clock.
// - Horizontal mask start is 13 bits, core clocks after horizontal sync.
// - Auxiliary horizontal mask start is a separate 13-bit field, same unit.
// - Horizontal mask range is 13 bits: window width in core clocks.
// - Vertical mask start is 13 bits, lines after vertical sync.
// - Vertical mask range is 13 bits: window height in lines.
// - Mask enable limits the clock to the valid area; clear passes it through.
// - Internal mode builds the internal clock from auxiliary settings, no switching.
// - Only the first valid-width field value plus one pattern bits are used.
// - Gating mode makes pattern bits core clock enables, otherwise clock levels.
`timescale 1ns/1ps
`default_nettype none
module lpc_pixel_clock_mask
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [lpc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output wire logic s_axi_awready,
   input wire logic [lpc_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [lpc_pkg::STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output wire logic s_axi_wready,
   output wire logic [1:0] s_axi_bresp,
   output wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [lpc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output wire logic s_axi_arready,
   output wire logic [lpc_pkg::DATA_W-1:0] s_axi_rdata,
   output wire logic [1:0] s_axi_rresp,
   output wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic hsync,
   input wire logic vsync,
   input wire logic culling_line_id,
   output var logic lcd_pixel_clock,
   output var logic lcd_pixel_clock_gate,
   output var logic internal_pixel_clock,
   output var logic internal_pixel_clock_gate
);
   import lpc_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   lpc_regbus_if bus ();

   logic [DATA_W-1:0] regs_ff [NREG];
   logic [DATA_W-1:0] nxt_regs [NREG];
   logic [DATA_W-1:0] strb_mask;
   logic [IDX_W-1:0] wr_idx;
   logic [IDX_W-1:0] rd_idx;

   logic hsync_d_ff;
   logic vsync_d_ff;
   logic nxt_hsync_d;
   logic nxt_vsync_d;
   logic hs_rise;
   logic vs_rise;
   logic [CNT_W-1:0] hcnt_ff, nxt_hcnt;
   logic [CNT_W-1:0] lcnt_ff, nxt_lcnt;

   logic [WIDTH_W-1:0] bit_idx;
   logic [PAT_BITS-1:0] pri_pattern;
   logic [PAT_BITS-1:0] aux_pattern;
   logic [WIDTH_W-1:0] valid_width;

   logic mask_en;
   logic gating_mode;
   logic int_mode;
   logic switch_en;

   logic use_aux_out;
   logic [CNT_W-1:0] hstart_out, hstart_int;
   logic [CNT_W-1:0] hrange, vstart, vrange;
   logic vwin;
   logic win_out;
   logic win_int;
   logic bit_out;
   logic bit_int;

   logic nxt_clk_out;
   logic nxt_gate_out;
   logic nxt_clk_int;
   logic nxt_gate_int;

   // ------------------------------------------------------------
   // Bus slave and pattern index
   // ------------------------------------------------------------
   lpc_axi_slave u_slave (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .bus(bus.slave)
   );

   lpc_pattern_stepper u_stepper (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .restart(hs_rise),
      .last_idx(valid_width),
      .idx_ff(bit_idx)
   );

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   assign wr_idx = lpc_idx(bus.wr_addr);
   assign rd_idx = lpc_idx(bus.rd_addr);

   always_comb begin
      for (int b = 0; b < STRB_W; b++) begin
         strb_mask[b*8 +: 8] = {8{bus.wr_strb[b]}};
      end
   end

   // Byte lanes and writable bits merge into the stored word
   always_comb begin
      for (int i = 0; i < NREG; i++) begin
         nxt_regs[i] = regs_ff[i];
         if (bus.wr_en && (wr_idx == IDX_W'(i))) begin
            nxt_regs[i] = (regs_ff[i] & ~(strb_mask & lpc_wmask(IDX_W'(i)))) |
                          (bus.wr_data & strb_mask & lpc_wmask(IDX_W'(i)));
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NREG; i++) begin
            regs_ff[i] <= REG_RESET;
         end
      end else begin
         for (int i = 0; i < NREG; i++) begin
            regs_ff[i] <= nxt_regs[i];
         end
      end
   end

   // Status word shows live counters and window state
   always_comb begin
      if (rd_idx == IDX_STATUS) begin
         bus.rd_data = '0;
         bus.rd_data[STAT_HCNT_LSB +: CNT_W] = hcnt_ff;
         bus.rd_data[STAT_LCNT_LSB +: CNT_W] = lcnt_ff;
         bus.rd_data[STAT_AUX_BIT] = use_aux_out;
         bus.rd_data[STAT_WIN_BIT] = win_out;
      end else if (rd_idx < IDX_STATUS) begin
         bus.rd_data = regs_ff[rd_idx];
      end else begin
         bus.rd_data = '0;
      end
   end

   // ------------------------------------------------------------
   // Configuration fields
   // ------------------------------------------------------------
   always_comb begin
      for (int w = 0; w < PAT_WORDS; w++) begin
         pri_pattern[w*PAT_W +: PAT_W] = regs_ff[IDX_PRI_WORD0 + IDX_W'(w)][PAT_W-1:0];
      end

      aux_pattern[0 +: 2*PAT_W] = {regs_ff[IDX_AUX_WORD0 + 4'h1][PAT_W-1:0],
                                   regs_ff[IDX_AUX_WORD0][PAT_W-1:0]};
      aux_pattern[2*PAT_W +: PAT_W] = regs_ff[IDX_AUX_WORD2][PAT_W-1:0];
      aux_pattern[3*PAT_W +: PAT_W] = regs_ff[IDX_AUX_WORD3][PAT_W-1:0];
   end

   assign valid_width = regs_ff[IDX_CTRL][CTRL_WIDTH_LSB +: WIDTH_W];
   assign mask_en = regs_ff[IDX_CTRL][CTRL_MASK_EN_BIT];
   assign gating_mode = regs_ff[IDX_CTRL][CTRL_GATING_BIT];
   assign int_mode = regs_ff[IDX_CTRL][CTRL_INT_MODE_BIT];
   assign switch_en = regs_ff[IDX_CTRL][CTRL_SWITCH_BIT];

   assign hrange = regs_ff[IDX_HRANGE][CNT_W-1:0];
   assign vstart = regs_ff[IDX_VSTART][CNT_W-1:0];
   assign vrange = regs_ff[IDX_VRANGE][CNT_W-1:0];

   // ------------------------------------------------------------
   // Sync edges and position counters
   // ------------------------------------------------------------
   // Timing generator runs on this clock, so sync inputs need no synchroniser
   assign hs_rise = hsync && !hsync_d_ff;
   assign vs_rise = vsync && !vsync_d_ff;

   always_comb begin
      nxt_hsync_d = hsync;
      nxt_vsync_d = vsync;
      if (hs_rise) begin
         nxt_hcnt = '0;
      end else if (hcnt_ff == CNT_MAX) begin
         nxt_hcnt = hcnt_ff;
      end else begin
         nxt_hcnt = hcnt_ff + 13'h0001;
      end

      if (vs_rise) begin
         nxt_lcnt = '0;
      end else if (hs_rise && (lcnt_ff != CNT_MAX)) begin
         nxt_lcnt = lcnt_ff + 13'h0001;
      end else begin
         nxt_lcnt = lcnt_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hsync_d_ff <= 1'b0;
         vsync_d_ff <= 1'b0;
         hcnt_ff <= '0;
         lcnt_ff <= '0;
      end else begin
         hsync_d_ff <= nxt_hsync_d;
         vsync_d_ff <= nxt_vsync_d;
         hcnt_ff <= nxt_hcnt;
         lcnt_ff <= nxt_lcnt;
      end
   end

   // ------------------------------------------------------------
   // Pattern and window selection
   // ------------------------------------------------------------
   // Switching by line ID is dead in internal mode
   assign use_aux_out = !int_mode && switch_en && culling_line_id;

   always_comb begin
      hstart_out = regs_ff[IDX_HSTART][CNT_W-1:0];
      if (use_aux_out) begin
         hstart_out = regs_ff[IDX_HSTART_AUX][CNT_W-1:0];
      end

      hstart_int = hstart_out;
      if (int_mode) begin
         hstart_int = regs_ff[IDX_HSTART_AUX][CNT_W-1:0];
      end
   end

   // Zero range gives no window
   assign vwin = lpc_in_window(lcnt_ff, vstart, vrange);
   assign win_out = !mask_en || (vwin && lpc_in_window(hcnt_ff, hstart_out, hrange));
   assign win_int = !mask_en || (vwin && lpc_in_window(hcnt_ff, hstart_int, hrange));

   assign bit_out = use_aux_out ? aux_pattern[bit_idx] : pri_pattern[bit_idx];
   assign bit_int = (int_mode || use_aux_out) ? aux_pattern[bit_idx] : pri_pattern[bit_idx];

   // ------------------------------------------------------------
   // Clock level and gate outputs
   // ------------------------------------------------------------
   always_comb begin
      if (gating_mode) begin
         nxt_clk_out = 1'b0;
         nxt_gate_out = bit_out && win_out;
         nxt_clk_int = 1'b0;
         nxt_gate_int = bit_int && win_int;
      end else begin
         nxt_clk_out = bit_out && win_out;
         nxt_gate_out = 1'b0;
         nxt_clk_int = bit_int && win_int;
         nxt_gate_int = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lcd_pixel_clock <= 1'b0;
         lcd_pixel_clock_gate <= 1'b0;
         internal_pixel_clock <= 1'b0;
         internal_pixel_clock_gate <= 1'b0;
      end else begin
         lcd_pixel_clock <= nxt_clk_out;
         lcd_pixel_clock_gate <= nxt_gate_out;
         internal_pixel_clock <= nxt_clk_int;
         internal_pixel_clock_gate <= nxt_gate_int;
      end
   end
endmodule
`default_nettype wire

// ==== tb/lpc_monitor.sv ====
// Port checker for the pixel clock pattern and mask block
`timescale 1ns/1ps
`default_nettype none
module lpc_monitor
   import lpc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [lpc_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic lcd_pixel_clock,
   input wire logic lcd_pixel_clock_gate,
   input wire logic internal_pixel_clock,
   input wire logic internal_pixel_clock_gate
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |-> ##[1:2] s_axi_rvalid) else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
   a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_addr_blocked: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second write address taken");
   a_out_mode: assert property (!(lcd_pixel_clock && lcd_pixel_clock_gate))
      else $error("level and gate both high");
   a_int_mode: assert property (!(internal_pixel_clock && internal_pixel_clock_gate))
      else $error("internal level and gate both high");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_gate: cover property (lcd_pixel_clock_gate);
   c_level: cover property ($rose(lcd_pixel_clock));
endmodule
bind lpc_pixel_clock_mask lpc_monitor u_mon (.*);
`default_nettype wire

// ==== tb/lpc_panel_model.sv ====
// Panel model counting data captures on the pixel clock
`timescale 1ns/1ps
`default_nettype none
module lpc_panel_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic lcd_pixel_clock,
   input wire logic lcd_pixel_clock_gate,
   output var logic [15:0] n_capture
);
   logic prev_ff;
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         n_capture <= 16'h0;
         prev_ff <= 1'h0;
      end else begin
         prev_ff <= lcd_pixel_clock;
         // Capture on a level rise or on a gated core clock
         if (lcd_pixel_clock_gate || (lcd_pixel_clock && !prev_ff)) begin
            n_capture <= n_capture + 16'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the pixel clock pattern and mask block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import lpc_pkg::*;
   logic ref_clk = 1'h0;
   logic reset_n = 1'h0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, lfsr = 32'h3B9352EF;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, pclk, pgate, iclk, igate;
   logic [1:0] bresp, rresp;
   logic hsync = 1'h0, vsync = 1'h0, cull = 1'h0;
   logic [15:0] n_capture;
   logic [31:0] regv [15] = '{default: 32'h0};
   logic [32:0] vid [8] = '{33'h000000014, 33'h000000414, 33'h000000C14, 33'h100010014,
      33'h000010014, 33'h100000014, 33'h000008414, 33'h10001043F};
   logic [7:0] bad [3] = '{8'h3C, 8'h40, 8'hFC};
   int n_mismatch = 0, n_compared = 0, n_cycle = 0;
   always #10 ref_clk = ~ref_clk;
   lpc_pixel_clock_mask dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .hsync(hsync), .vsync(vsync), .culling_line_id(cull), .lcd_pixel_clock(pclk),
      .lcd_pixel_clock_gate(pgate), .internal_pixel_clock(iclk),
      .internal_pixel_clock_gate(igate));
   lpc_panel_model panel (.ref_clk(ref_clk), .reset_n(reset_n), .lcd_pixel_clock(pclk),
      .lcd_pixel_clock_gate(pgate), .n_capture(n_capture));
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      next_rand = {s[30:0], 1'h0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
   endfunction
   function automatic logic [31:0] wmask(input int i);
      wmask = (i == 0) ? CTRL_WMASK : (i < 9) ? PAT_WMASK : POS_WMASK;
   endfunction
   // Expected pattern bit at count k, for the panel or the internal side
   function automatic logic exp_bit(input int k, input logic side);
      logic aux;
      logic [63:0] pat;
      int b;
      int hs;
      aux = regv[0][15] ? side : (regv[0][16] && cull);
      b = aux ? 5 : 1;
      pat = {regv[b+3][15:0], regv[b+2][15:0], regv[b+1][15:0], regv[b][15:0]};
      hs = aux ? regv[10] : regv[9];
      exp_bit = pat[k % (regv[0][5:0] + 1)] && (!regv[0][10] || (k >= hs
         && k < hs + regv[11] && regv[12] <= 1 && 1 < regv[12] + regv[13]));
   endfunction
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      chk_word({30'h0, got}, {30'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad = 1'h0;
      logic dd = 1'h0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!(ad && dd)) begin
         @(posedge ref_clk);
         if (!ad && awready) begin
            ad = 1'h1;
            awvalid <= 1'h0;
         end
         if (!dd && wready) begin
            dd = 1'h1;
            wvalid <= 1'h0;
         end
      end
      repeat (2) @(posedge ref_clk);
      bready <= 1'h1;
      do @(posedge ref_clk); while (!bvalid);
      bready <= 1'h0;
      chk_resp(bresp, er);
      if (er == RESP_OKAY && a < 8'h38) regv[a[5:2]] = d & wmask(a[5:2]);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'h1;
      do @(posedge ref_clk); while (!arready);
      arvalid <= 1'h0;
      @(posedge ref_clk);
      rready <= 1'h1;
      do @(posedge ref_clk); while (!rvalid);
      rready <= 1'h0;
      chk_word(rdata, ed);
      chk_resp(rresp, er);
   endtask
   // One frame start, one line start, then n output cycles compared
   task automatic run_line(input int n);
      logic [3:0] e;
      logic g;
      logic prev = 1'h0;
      int c0;
      int ne = 0;
      g = regv[0][11];
      @(posedge ref_clk);
      vsync <= 1'h1;
      @(posedge ref_clk);
      vsync <= 1'h0;
      @(posedge ref_clk);
      hsync <= 1'h1;
      @(posedge ref_clk);
      hsync <= 1'h0;
      @(posedge ref_clk);
      for (int k = 0; k < n; k++) begin
         #1;
         e = {exp_bit(k, 0) & !g, exp_bit(k, 0) & g, exp_bit(k, 1) & !g, exp_bit(k, 1) & g};
         chk_word({28'h0, pclk, pgate, iclk, igate}, {28'h0, e});
         if (k == 1) c0 = n_capture;
         if (k == n - 1) chk_word(32'(n_capture) - c0, ne);
         if (k >= 1 && k < n - 1) ne += e[2] + (e[3] && !prev);
         prev = e[3];
         @(posedge ref_clk);
      end
   endtask
   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      n_cycle++;
      if (n_cycle == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'h1;
      for (int i = 0; i < 14; i++) rd(8'(i * 4), REG_RESET, RESP_OKAY);
      for (int i = 0; i < 14; i++) begin
         lfsr = next_rand(lfsr);
         wr(8'(i * 4), lfsr, RESP_OKAY);
         rd(8'(i * 4), lfsr & wmask(i), RESP_OKAY);
      end
      wr(8'h38, 32'hFFFFFFFF, RESP_OKAY);
      for (int j = 0; j < 3; j++) begin
         wr(bad[j], 32'hFFFFFFFF, RESP_SLVERR);
         rd(bad[j], 32'h0, RESP_SLVERR);
      end
      wr(8'h24, 32'h3, RESP_OKAY);
      wr(8'h28, 32'h7, RESP_OKAY);
      wr(8'h2C, 32'h5, RESP_OKAY);
      wr(8'h30, 32'h0, RESP_OKAY);
      wr(8'h34, 32'h2, RESP_OKAY);
      for (int j = 0; j < 8; j++) begin
         cull <= vid[j][32];
         wr(8'h00, vid[j][31:0], RESP_OKAY);
         run_line(2 * (vid[j][5:0] + 1) + 2);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
